// >>> hw/tcvm_filter.sv
// Purpose: Per-port class filter for received packet headers
// Assumes: One header per valid cycle, synchronous inputs
// Notes:   Dropped packets never return credits
//
// Contract
// - Class zero always rides channel zero
// - Channel established only with a mapped class
// - Each class resolves to one enabled channel
// - Other mappings and channels set by software
// - Any subset of classes may share channel
// - Each port holds its own map
// - Same class may use different channels per port
// - Unmapped class packets dropped as malformed
// - Drop keeps credits, raises uncorrectable error
// - Drop sends fatal message, logs first dropped header only
module tcvm_filter
(
   input  wire  logic                                         MCLK,
   input  wire  logic                                         SYS_RST,
   input  wire  logic                                         RX_VALID,
   input  wire  logic [tcvm_pkg::PORT_W-1:0]                  RX_PORT,
   input  wire  logic [tcvm_pkg::HDR_W-1:0]                   RX_HDR,
   input  wire  logic                                         MAP_WR,
   input  wire  logic [tcvm_pkg::PORT_W-1:0]                  MAP_PORT,
   input  wire  logic [tcvm_pkg::TC_W-1:0]                    MAP_TC,
   input  wire  logic [tcvm_pkg::VC_W-1:0]                    MAP_VC,
   input  wire  logic                                         MAP_VALID,
   input  wire  logic [tcvm_pkg::NUM_PORTS*tcvm_pkg::NUM_VC-1:0] VC_ENABLE,
   output       logic                                         FWD_VALID,
   output       logic [tcvm_pkg::PORT_W-1:0]                  FWD_PORT,
   output       logic [tcvm_pkg::VC_W-1:0]                    FWD_VC,
   output       logic [tcvm_pkg::HDR_W-1:0]                   FWD_HDR,
   output       logic                                         CREDIT_RET,
   output       logic                                         DROP_PULSE,
   output       logic                                         ERR_UNCOR,
   output       logic                                         ERR_FATAL_MSG,
   output       logic [tcvm_pkg::HDR_W-1:0]                   ERR_HDR_LOG,
   output       logic                                         ERR_LOGGED
);
   tcvm_pkg::tcvm_state_t             state;
   tcvm_pkg::tcvm_state_t             next_state;
   logic [tcvm_pkg::NUM_PORTS-1:0]    port_hit;
   logic [tcvm_pkg::VC_W-1:0]         port_vc [tcvm_pkg::NUM_PORTS];
   logic [tcvm_pkg::TC_W-1:0]         rx_tc;
   logic                              sel_hit;
   logic [tcvm_pkg::VC_W-1:0]         sel_vc;
   logic                              next_fwd_valid;
   logic [tcvm_pkg::PORT_W-1:0]       next_fwd_port;
   logic [tcvm_pkg::VC_W-1:0]         next_fwd_vc;
   logic [tcvm_pkg::HDR_W-1:0]        next_fwd_hdr;
   logic                              next_credit_ret;
   logic                              next_drop_pulse;
   logic                              next_err_uncor;
   logic                              next_err_fatal;
   logic [tcvm_pkg::HDR_W-1:0]        next_err_hdr;
   logic                              next_err_logged;

   assign rx_tc = RX_HDR[tcvm_pkg::TC_LSB +: tcvm_pkg::TC_W];

   // ****************************************
   // One independent map per port
   // ****************************************
   genvar gp;
   generate
      for (gp = 0; gp < tcvm_pkg::NUM_PORTS; gp++)
      begin : g_port
         localparam int PORT_ID = gp;
         tcvm_map_if lk ();
         assign lk.tc        = rx_tc;
         assign port_hit[gp] = lk.hit;
         assign port_vc[gp]  = lk.vc;
         tcvm_port_map u_map
         (
            .MCLK     (MCLK),
            .SYS_RST  (SYS_RST),
            .wr_en    (MAP_WR && (MAP_PORT == PORT_ID[tcvm_pkg::PORT_W-1:0])),
            .wr_tc    (MAP_TC),
            .wr_vc    (MAP_VC),
            .wr_valid (MAP_VALID),
            .vc_en_in (VC_ENABLE[gp*tcvm_pkg::NUM_VC +: tcvm_pkg::NUM_VC]),
            .lk       (lk.server)
         );
      end
   endgenerate

   assign sel_hit = port_hit[RX_PORT];
   assign sel_vc  = port_vc[RX_PORT];

   // ****************************************
   // Filter decision
   // ****************************************
   // Pulses last one cycle; data, log and error levels hold
   always_comb
   begin
      next_state      = tcvm_pkg::TCVM_IDLE;
      next_fwd_valid  = 1'b0;
      next_fwd_port   = FWD_PORT;
      next_fwd_vc     = FWD_VC;
      next_fwd_hdr    = FWD_HDR;
      next_credit_ret = 1'b0;
      next_drop_pulse = 1'b0;
      next_err_uncor  = ERR_UNCOR;
      next_err_fatal  = 1'b0;
      next_err_hdr    = ERR_HDR_LOG;
      next_err_logged = ERR_LOGGED;
      if (RX_VALID)
      begin
         case (sel_hit)
            1'b1:
            begin
               next_state      = tcvm_pkg::TCVM_PASS;
               next_fwd_valid  = 1'b1;
               next_fwd_port   = RX_PORT;
               next_fwd_vc     = sel_vc;
               next_fwd_hdr    = RX_HDR;
               next_credit_ret = 1'b1;
            end
            default:
            begin
               next_state      = tcvm_pkg::TCVM_DROP;
               next_drop_pulse = 1'b1;
               next_err_uncor  = 1'b1;
               next_err_fatal  = 1'b1;
               // Log keeps the first dropped header only
               if (!ERR_LOGGED)
               begin
                  next_err_hdr    = RX_HDR;
                  next_err_logged = 1'b1;
               end
            end
         endcase
      end
   end

   // Every output comes straight from a flop
   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state         <= tcvm_pkg::TCVM_IDLE;
         FWD_VALID     <= 1'b0;
         FWD_PORT      <= '0;
         FWD_VC        <= '0;
         FWD_HDR       <= '0;
         CREDIT_RET    <= 1'b0;
         DROP_PULSE    <= 1'b0;
         ERR_UNCOR     <= 1'b0;
         ERR_FATAL_MSG <= 1'b0;
         ERR_HDR_LOG   <= '0;
         ERR_LOGGED    <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         FWD_VALID     <= next_fwd_valid;
         FWD_PORT      <= next_fwd_port;
         FWD_VC        <= next_fwd_vc;
         FWD_HDR       <= next_fwd_hdr;
         CREDIT_RET    <= next_credit_ret;
         DROP_PULSE    <= next_drop_pulse;
         ERR_UNCOR     <= next_err_uncor;
         ERR_FATAL_MSG <= next_err_fatal;
         ERR_HDR_LOG   <= next_err_hdr;
         ERR_LOGGED    <= next_err_logged;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence s_bad_rx;
      RX_VALID && !sel_hit;
   endsequence
   sequence s_drop_out;
      DROP_PULSE && !FWD_VALID && !CREDIT_RET && ERR_FATAL_MSG;
   endsequence
   sequence s_good_rx;
      RX_VALID && sel_hit;
   endsequence

   chk_drop_unmapped: assert property (@(posedge MCLK) disable iff (SYS_RST)
      s_bad_rx |=> s_drop_out)
      else $error("unmapped packet not dropped");
   chk_credit_kept: assert property (@(posedge MCLK) disable iff (SYS_RST)
      DROP_PULSE |-> (ERR_UNCOR && !CREDIT_RET))
      else $error("credit returned on drop");
   chk_uncor_sticky: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ERR_UNCOR |=> ERR_UNCOR)
      else $error("error flag cleared");
   chk_hdr_logged: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (s_bad_rx and !ERR_LOGGED) |=> (ERR_LOGGED && ERR_HDR_LOG == $past(RX_HDR)))
      else $error("header not logged");
   chk_pass_mapped: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (RX_VALID && sel_hit) |=> (FWD_VALID && CREDIT_RET && FWD_VC == $past(sel_vc)))
      else $error("mapped packet not forwarded");
   chk_tc0_passes: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (RX_VALID && rx_tc == tcvm_pkg::TC_DEFAULT)
      |=> (FWD_VALID && FWD_VC == tcvm_pkg::VC_DEFAULT))
      else $error("class zero not forwarded on channel zero");
   chk_state_onehot: assert property (@(posedge MCLK) disable iff (SYS_RST)
      $onehot(state) && ((state == tcvm_pkg::TCVM_DROP) == DROP_PULSE))
      else $error("state out of step");
   chk_exclusive_out: assert property (@(posedge MCLK) disable iff (SYS_RST)
      !(FWD_VALID && DROP_PULSE))
      else $error("packet both forwarded and dropped");
   chk_credit_paired: assert property (@(posedge MCLK) disable iff (SYS_RST)
      CREDIT_RET == FWD_VALID)
      else $error("credit return not paired with forward");
   chk_fatal_paired: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ERR_FATAL_MSG == DROP_PULSE)
      else $error("fatal message not paired with drop");
   chk_log_held: assert property (@(posedge MCLK) disable iff (SYS_RST)
      ERR_LOGGED |=> (ERR_LOGGED && $stable(ERR_HDR_LOG)))
      else $error("header log overwritten");
   chk_idle_quiet: assert property (@(posedge MCLK) disable iff (SYS_RST)
      !RX_VALID |=> (!FWD_VALID && !DROP_PULSE))
      else $error("output without received packet");
   chk_fwd_copy: assert property (@(posedge MCLK) disable iff (SYS_RST)
      s_good_rx |=> (FWD_HDR == $past(RX_HDR) && FWD_PORT == $past(RX_PORT)))
      else $error("forwarded header or port wrong");
   chk_drop_flags: assert property (@(posedge MCLK) disable iff (SYS_RST)
      s_bad_rx |=> (ERR_UNCOR && ERR_LOGGED))
      else $error("drop did not raise error");
endmodule

// >>> hw/tcvm_pkg.sv
// Purpose: Shared constants and types for the class-to-channel map and filter
// Assumes: Eight classes, eight channel identifiers, fixed port count
// Notes:   Every number used by the design is named here once
package tcvm_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_PORTS  = 2;
   localparam int TC_W       = 3;
   localparam int NUM_TC     = 8;
   localparam int VC_W       = 3;
   localparam int NUM_VC     = 8;
   localparam int HDR_W      = 32;
   localparam int PORT_W     = 1;

   // ****************************************
   // Header field position and fixed pair
   // ****************************************
   localparam int              TC_LSB        = 20;
   localparam logic [TC_W-1:0] TC_DEFAULT    = 3'h0;
   localparam logic [VC_W-1:0] VC_DEFAULT    = 3'h0;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [NUM_TC-1:0] MAP_VALID_RST = 8'h01;
   localparam logic [NUM_VC-1:0] VC_EN_RST     = 8'h01;
   localparam logic [VC_W-1:0]   MAP_VC_RST    = 3'h0;

   typedef enum logic [2:0]
   {
      TCVM_IDLE = 3'b001,
      TCVM_PASS = 3'b010,
      TCVM_DROP = 3'b100
   } tcvm_state_t;

endpackage

// >>> hw/tcvm_map_if.sv
// Purpose: Carries one port's lookup request and answer
// Assumes: Single clock
// Notes:   Top side drives the class, map side answers combinationally
interface tcvm_map_if;
   logic [tcvm_pkg::TC_W-1:0] tc;
   logic [tcvm_pkg::VC_W-1:0] vc;
   logic                      hit;

   modport client
   (
      output tc,
      input  vc,
      input  hit
   );
   modport server
   (
      input  tc,
      output vc,
      output hit
   );
endinterface

// >>> hw/tcvm_port_map.sv
// Purpose: One port's own class-to-channel map with lookup
// Assumes: Writes come from software configuration pins
// Notes:   Class zero entry is hard wired to channel zero
module tcvm_port_map
(
   input  wire logic                          MCLK,
   input  wire logic                          SYS_RST,
   input  wire logic                          wr_en,
   input  wire logic [tcvm_pkg::TC_W-1:0]     wr_tc,
   input  wire logic [tcvm_pkg::VC_W-1:0]     wr_vc,
   input  wire logic                          wr_valid,
   input  wire logic [tcvm_pkg::NUM_VC-1:0]   vc_en_in,
   tcvm_map_if.server                         lk
);
   logic [tcvm_pkg::VC_W-1:0]   map_vc [tcvm_pkg::NUM_TC];
   logic [tcvm_pkg::NUM_TC-1:0] map_valid;
   logic [tcvm_pkg::VC_W-1:0]   next_map_vc [tcvm_pkg::NUM_TC];
   logic [tcvm_pkg::NUM_TC-1:0] next_map_valid;
   logic [tcvm_pkg::NUM_VC-1:0] vc_en;

   // ****************************************
   // Map update
   // ****************************************
   always_comb
   begin
      next_map_vc    = map_vc;
      next_map_valid = map_valid;
      if (wr_en && (wr_tc != tcvm_pkg::TC_DEFAULT))
      begin
         next_map_vc[wr_tc]    = wr_vc;
         next_map_valid[wr_tc] = wr_valid;
      end
      next_map_vc[tcvm_pkg::TC_DEFAULT]    = tcvm_pkg::VC_DEFAULT;
      next_map_valid[tcvm_pkg::TC_DEFAULT] = 1'b1;
   end

   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         for (int i = 0; i < tcvm_pkg::NUM_TC; i++)
         begin
            map_vc[i] <= tcvm_pkg::MAP_VC_RST;
         end
         map_valid <= tcvm_pkg::MAP_VALID_RST;
      end
      else
      begin
         map_vc    <= next_map_vc;
         map_valid <= next_map_valid;
      end
   end

   // Channel zero always enabled
   assign vc_en = vc_en_in | tcvm_pkg::VC_EN_RST;

   // ****************************************
   // Lookup
   // ****************************************
   always_comb
   begin
      lk.vc  = map_vc[lk.tc];
      lk.hit = map_valid[lk.tc] && vc_en[map_vc[lk.tc]];
   end

   chk_default_pair: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (lk.tc == tcvm_pkg::TC_DEFAULT) |-> (lk.hit && lk.vc == tcvm_pkg::VC_DEFAULT))
      else $error("class zero not on channel zero");
   chk_write_takes: assert property (@(posedge MCLK) disable iff (SYS_RST)
      (wr_en && wr_tc != tcvm_pkg::TC_DEFAULT)
      |=> (map_vc[$past(wr_tc)] == $past(wr_vc) && map_valid[$past(wr_tc)] == $past(wr_valid)))
      else $error("map write not stored");
   chk_hit_enabled: assert property (@(posedge MCLK) disable iff (SYS_RST)
      lk.hit |-> (vc_en[lk.vc] && map_valid[lk.tc]))
      else $error("hit on unestablished channel");
endmodule

// >>> test/tcvm_link_partner.sv
// Purpose: Link partner that sends received packet headers
// Assumes: Caller enters just after a rising edge
// Notes:   Released lines show the inverse of the last value
module tcvm_link_partner
(
   input  wire logic                          mclk,
   output      logic                          rx_valid,
   output      logic [tcvm_pkg::PORT_W-1:0]   rx_port,
   output      logic [tcvm_pkg::HDR_W-1:0]    rx_hdr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      rx_valid = 1'b0;
      rx_port  = 1'h0;
      rx_hdr   = 32'h0;
   end

   task automatic put(input logic [tcvm_pkg::PORT_W-1:0] p, input logic [31:0] h);
      rx_valid = 1'b1;
      rx_port  = p;
      rx_hdr   = h;
      @(posedge mclk);
      #1;
   endtask

   task automatic idle();
      rx_valid = 1'b0;
      rx_port  = ~rx_port;
      rx_hdr   = ~rx_hdr;
      @(posedge mclk);
      #1;
   endtask
endmodule

// >>> test/tc_vc_map_and_filter_tb.sv
// Purpose: Self-checking bench for the class-to-channel filter
// Assumes: Outputs answer on the same edge that takes the header
// Notes:   Inputs change 1 ns after the rising edge
module tc_vc_map_and_filter_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Signals
   // ****************************************
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        rx_valid;
   logic        rx_port;
   logic [31:0] rx_hdr;
   logic        map_wr = 1'b0;
   logic        map_port = 1'b0;
   logic [2:0]  map_tc = 3'h0;
   logic [2:0]  map_vc = 3'h0;
   logic        map_valid = 1'b0;
   logic [15:0] vc_en = 16'h0001;
   logic        fwd_valid, fwd_port, credit_ret, drop_pulse, err_uncor, err_fatal, err_logged;
   logic [2:0]  fwd_vc;
   logic [31:0] fwd_hdr, err_hdr;
   logic [19:0] seq = 20'h0;
   logic        have_drop = 1'b0;
   logic [31:0] log_exp = 32'h0;
   int          num_errors = 0;
   int          check_count = 0;

   always #20 mclk = ~mclk;

   tcvm_link_partner tcvm_link_partner_i
   (
      .mclk     (mclk),
      .rx_valid (rx_valid),
      .rx_port  (rx_port),
      .rx_hdr   (rx_hdr)
   );

   tcvm_filter tcvm_filter_i
   (
      .MCLK          (mclk),
      .SYS_RST       (rst),
      .RX_VALID      (rx_valid),
      .RX_PORT       (rx_port),
      .RX_HDR        (rx_hdr),
      .MAP_WR        (map_wr),
      .MAP_PORT      (map_port),
      .MAP_TC        (map_tc),
      .MAP_VC        (map_vc),
      .MAP_VALID     (map_valid),
      .VC_ENABLE     (vc_en),
      .FWD_VALID     (fwd_valid),
      .FWD_PORT      (fwd_port),
      .FWD_VC        (fwd_vc),
      .FWD_HDR       (fwd_hdr),
      .CREDIT_RET    (credit_ret),
      .DROP_PULSE    (drop_pulse),
      .ERR_UNCOR     (err_uncor),
      .ERR_FATAL_MSG (err_fatal),
      .ERR_HDR_LOG   (err_hdr),
      .ERR_LOGGED    (err_logged)
   );

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic do_reset();
      rst = 1'b1;
      #1;
      chk("rst_out", 32'h0, {fwd_valid, credit_ret, drop_pulse, err_uncor, err_fatal, err_logged});
      chk("rst_log", 32'h0, err_hdr);
      repeat (3) @(posedge mclk);
      #1;
      rst = 1'b0;
      have_drop = 1'b0;
   endtask

   task automatic wr(input logic p, input logic [2:0] tc, input logic [2:0] vc, input logic v);
      map_wr = 1'b1;
      map_port = p;
      map_tc = tc;
      map_vc = vc;
      map_valid = v;
      @(posedge mclk);
      #1;
      map_wr = 1'b0;
      @(posedge mclk);
      #1;
   endtask

   task automatic pkt(input logic p, input logic [2:0] tc, input logic fwd, input logic [2:0] vc);
      logic [31:0] h;
      seq++;
      h = {9'h0A5, tc, seq};
      tcvm_link_partner_i.put(p, h);
      chk("fwd_valid", fwd, fwd_valid);
      chk("credit_ret", fwd, credit_ret);
      chk("drop_pulse", !fwd, drop_pulse);
      chk("fatal_msg", !fwd, err_fatal);
      if (fwd)
      begin
         chk("fwd_vc", vc, fwd_vc);
         chk("fwd_port", p, fwd_port);
         chk("fwd_hdr", h, fwd_hdr);
      end
      else
      begin
         if (!have_drop)
            log_exp = h;
         have_drop = 1'b1;
         chk("err_uncor", 1'b1, err_uncor);
         chk("err_logged", 1'b1, err_logged);
      end
      if (have_drop)
         chk("err_hdr_log", log_exp, err_hdr);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_default();
      pkt(1'b0, 3'h0, 1'b1, 3'h0);
      pkt(1'b1, 3'h0, 1'b1, 3'h0);
      pkt(1'b0, 3'h5, 1'b0, 3'h0);
      pkt(1'b1, 3'h2, 1'b0, 3'h0);
      tcvm_link_partner_i.idle();
      chk("pulses_idle", 32'h0, {fwd_valid, credit_ret, drop_pulse, err_fatal});
      chk("uncor_level", 1'b1, err_uncor);
   endtask

   task automatic t_tc0_fixed();
      wr(1'b0, 3'h0, 3'h3, 1'b0);
      vc_en = 16'h0000;
      wr(1'b1, 3'h0, 3'h5, 1'b0);
      pkt(1'b0, 3'h0, 1'b1, 3'h0);
      pkt(1'b1, 3'h0, 1'b1, 3'h0);
      tcvm_link_partner_i.idle();
   endtask

   task automatic t_per_port();
      vc_en = 16'h0201;
      wr(1'b1, 3'h7, 3'h1, 1'b1);
      wr(1'b0, 3'h7, 3'h0, 1'b1);
      pkt(1'b0, 3'h7, 1'b1, 3'h0);
      pkt(1'b1, 3'h7, 1'b1, 3'h1);
      tcvm_link_partner_i.idle();
   endtask

   task automatic t_vc_enable();
      wr(1'b0, 3'h3, 3'h2, 1'b1);
      pkt(1'b0, 3'h3, 1'b0, 3'h0);
      tcvm_link_partner_i.idle();
      vc_en = 16'h0205;
      pkt(1'b0, 3'h3, 1'b1, 3'h2);
      pkt(1'b1, 3'h3, 1'b0, 3'h0);
      tcvm_link_partner_i.idle();
   endtask

   task automatic t_subset();
      vc_en = 16'h0211;
      for (int i = 1; i < 8; i++)
         wr(1'b0, 3'(i), 3'h4, 1'b1);
      for (int i = 0; i < 8; i++)
         pkt(1'b0, 3'(i), 1'b1, (i == 0) ? 3'h0 : 3'h4);
      wr(1'b0, 3'h6, 3'h4, 1'b0);
      pkt(1'b0, 3'h6, 1'b0, 3'h0);
      tcvm_link_partner_i.idle();
   endtask

   task automatic t_rereset();
      chk("uncor_held", 1'b1, err_uncor);
      do_reset();
      pkt(1'b0, 3'h7, 1'b0, 3'h0);
      tcvm_link_partner_i.idle();
   endtask

   // ****************************************
   // Sequence and verdict
   // ****************************************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      @(posedge mclk);
      #1;
      do_reset();
      t_default();
      t_tc0_fixed();
      t_per_port();
      t_vc_enable();
      t_subset();
      t_rereset();
      end_sim();
   end

   initial
   begin
      #(40 * 2000);
      num_errors++;
      end_sim();
   end
endmodule
